// >>> logic/incdec_pkg.sv
// Purpose: Shared constants for the decimal-adjust / inc / dec / power-down unit
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   Offsets, field positions, reset values and operation codes live here
package incdec_pkg;

    // Register byte offsets
    localparam logic [7:0] ACCUM_OFS  = 8'h00;
    localparam logic [7:0] DATA_OFS   = 8'h04;
    localparam logic [7:0] FLAGS_OFS  = 8'h08;
    localparam logic [7:0] CMD_OFS    = 8'h0C;
    localparam logic [7:0] WATCHDOG_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // Flag register field positions
    localparam int CARRY_BIT = 0;
    localparam int AUX_BIT   = 1;
    localparam int ZERO_BIT  = 2;
    localparam int PWRDN_BIT = 3;
    localparam int TMO_BIT   = 4;

    // Status register field positions
    localparam int HALTED_BIT = 0;

    // Reset values
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Decimal adjust constants
    localparam logic [3:0] NIBBLE_MAX = 4'h9;
    localparam logic [7:0] CORR_NONE  = 8'h00;
    localparam logic [7:0] CORR_LOW   = 8'h06;
    localparam logic [7:0] CORR_HIGH  = 8'h60;
    localparam logic [7:0] CORR_BOTH  = 8'h66;
    localparam logic [7:0] ONE        = 8'h01;

    // Operation codes written to the command register
    typedef enum logic [2:0] {
        OP_NOP                         = 3'h0,
        OP_DECIMAL_ADJUST_OP           = 3'h1,
        OP_DECREMENT_IN_PLACE_OP       = 3'h2,
        OP_DECREMENT_TO_ACCUMULATOR_OP = 3'h3,
        OP_INCREMENT_IN_PLACE_OP       = 3'h4,
        OP_POWER_DOWN_OP               = 3'h5
    } op_t;

    // Core mode; single bit so the path is Gray by construction
    typedef enum logic {
        MODE_RUN    = 1'b0,
        MODE_HALTED = 1'b1
    } mode_t;

endpackage

// >>> logic/alu_if.sv
// Purpose: Carries operands and results between the core and its arithmetic unit
// Assumes: Purely combinational path inside one clock domain
// Notes:   core drives operands, unit returns results
`timescale 1ns/10ps
interface alu_if;
    incdec_pkg::op_t op;
    logic [7:0]      accumulator;
    logic [7:0]      memByte;
    logic            carryIn;
    logic            auxiliaryCarryFlag;
    logic [7:0]      result;
    logic            carryOut;
    logic            zeroOut;
    logic            lowAdjust;
    logic            highAdjust;

    modport core (output op, accumulator, memByte, carryIn, auxiliaryCarryFlag,
                  input result, carryOut, zeroOut, lowAdjust, highAdjust);
    modport unit (input op, accumulator, memByte, carryIn, auxiliaryCarryFlag,
                  output result, carryOut, zeroOut, lowAdjust, highAdjust);
endinterface

// >>> logic/incdec_alu.sv
// Purpose: Combinational arithmetic for decimal adjust, increment and decrement
// Assumes: Operands are stable for the whole cycle in which a command fires
// Notes:   No state; the core decides where the result is written
`timescale 1ns/10ps
module incdec_alu (
    alu_if.unit bus
);

    // Nibble above nine, used for both digits
    function automatic logic overNine(input logic [3:0] nib);
        overNine = nib > incdec_pkg::NIBBLE_MAX;
    endfunction

    logic [7:0] corr;
    logic [8:0] sum;

    // Pick the correction and form the result for each operation
    always_comb begin
        bus.lowAdjust  = overNine(bus.accumulator[3:0]) | bus.auxiliaryCarryFlag;
        bus.highAdjust = overNine(bus.accumulator[7:4]) | bus.carryIn;
        case ({bus.highAdjust, bus.lowAdjust})
            2'b01:   corr = incdec_pkg::CORR_LOW;
            2'b10:   corr = incdec_pkg::CORR_HIGH;
            2'b11:   corr = incdec_pkg::CORR_BOTH;
            default: corr = incdec_pkg::CORR_NONE;
        endcase
        sum          = {1'b0, bus.accumulator} + {1'b0, corr};
        bus.carryOut = bus.carryIn;
        case (bus.op)
            incdec_pkg::OP_DECIMAL_ADJUST_OP: begin
                bus.result   = sum[7:0];
                // Carry chains multi-byte BCD sums; it never clears here
                bus.carryOut = bus.carryIn | bus.highAdjust | sum[8];
            end
            incdec_pkg::OP_DECREMENT_IN_PLACE_OP,
            incdec_pkg::OP_DECREMENT_TO_ACCUMULATOR_OP: begin
                bus.result = bus.memByte - incdec_pkg::ONE;
            end
            incdec_pkg::OP_INCREMENT_IN_PLACE_OP: begin
                bus.result = bus.memByte + incdec_pkg::ONE;
            end
            default: begin
                bus.result = bus.memByte;
            end
        endcase
        bus.zeroOut = (bus.result == 8'h00);
    end

endmodule // incdec_alu

// >>> logic/decimal_adjust_incdec_halt_exec.sv
// Purpose: Executes decimal adjust, decrement, increment and power-down over APB
// Assumes: APB slave with zero wait states; clk 25 MHz; rst asynchronous high
// Notes:   The data byte register stands in for the addressed data memory byte
// Operation
// - Low nibble over nine or aux: add six
// - High nibble over nine or carry: add six
// - Add 00H/06H/60H/66H, store into data byte
// - Decimal adjust touches only carry, sets on overflow
// - Decrement data byte in place, update zero
// - Decrement into accumulator, data byte unchanged
// - Power-down stops execution and system clock
// - Contents kept while powered down; APB writes to accumulator, data byte and flags are still taken while halted
// - Power-down clears watchdog counter and prescaler
// - Power-down sets power-down flag, clears timeout
// - Increment data byte in place
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module decimal_adjust_incdec_halt_exec #(
    parameter int WATCHDOG_WIDTH = 8,
    parameter int PRESC_WIDTH = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wakeUp,
    output logic             sysClkOn,
    output logic             powerDownFlag,
    output logic             timeoutFlag
);

    typedef struct packed {
        incdec_pkg::mode_t      mode;
        logic [7:0]             accumulator;
        logic [7:0]             dataByte;
        logic                   carry;
        logic                   auxiliaryCarryFlag;
        logic                   zero;
        logic                   powerDownFlag;
        logic                   timeoutFlag;
        logic [WATCHDOG_WIDTH-1:0] watchdogCounter;
        logic [PRESC_WIDTH-1:0] prescaler;
        logic [31:0]            readData;
    } state_t;

    state_t state_reg;
    state_t state_next;

    alu_if aluBus ();

    incdec_alu u_alu (
        .bus (aluBus.unit)
    );

    // Address decode shared by the write strobe and the error answer
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == incdec_pkg::ACCUM_OFS) || (a == incdec_pkg::DATA_OFS) ||
                 (a == incdec_pkg::FLAGS_OFS) || (a == incdec_pkg::CMD_OFS) ||
                 (a == incdec_pkg::WATCHDOG_OFS) || (a == incdec_pkg::STATUS_OFS);
    endfunction

    logic            setupPhase;
    logic            writeDone;
    logic            cmdWrite;
    logic            cmdFire;
    incdec_pkg::op_t cmdOp;
    logic            wdtWrap;

    // Bus phases; zero wait states so every access completes at once
    assign setupPhase = psel & ~penable;
    assign writeDone  = psel & penable & pwrite & mapped(paddr);
    assign cmdWrite   = writeDone & (paddr == incdec_pkg::CMD_OFS);
    assign cmdOp      = incdec_pkg::op_t'(pwdata[2:0]);
    // Commands are ignored while halted: no fetch, no execution
    assign cmdFire    = cmdWrite & (state_reg.mode == incdec_pkg::MODE_RUN);
    assign wdtWrap    = (&state_reg.prescaler) & (&state_reg.watchdogCounter);

    // Operands for the arithmetic unit come straight from the registers
    assign aluBus.op                 = cmdOp;
    assign aluBus.accumulator        = state_reg.accumulator;
    assign aluBus.memByte            = state_reg.dataByte;
    assign aluBus.carryIn            = state_reg.carry;
    assign aluBus.auxiliaryCarryFlag = state_reg.auxiliaryCarryFlag;

    // Next-state logic: watchdog, register writes, command execution, read capture
    always_comb begin
        state_next = state_reg;
        // Watchdog runs off the system clock, so it freezes while halted
        if (state_reg.mode == incdec_pkg::MODE_RUN) begin
            state_next.prescaler = state_reg.prescaler + 1'b1;
            if (&state_reg.prescaler) begin
                state_next.watchdogCounter = state_reg.watchdogCounter + 1'b1;
            end
            if (wdtWrap) begin
                state_next.timeoutFlag = 1'b1;
            end
        end
        // Plain register writes; flag writes only reach the arithmetic flags
        if (writeDone && !cmdWrite) begin
            case (paddr)
                incdec_pkg::ACCUM_OFS: state_next.accumulator = pwdata[7:0];
                incdec_pkg::DATA_OFS: state_next.dataByte    = pwdata[7:0];
                incdec_pkg::FLAGS_OFS: begin
                    state_next.carry              = pwdata[incdec_pkg::CARRY_BIT];
                    state_next.auxiliaryCarryFlag = pwdata[incdec_pkg::AUX_BIT];
                    state_next.zero               = pwdata[incdec_pkg::ZERO_BIT];
                end
                default: begin
                end
            endcase
        end
        // Command execution
        if (cmdFire) begin
            case (cmdOp)
                incdec_pkg::OP_DECIMAL_ADJUST_OP: begin
                    state_next.dataByte = aluBus.result;
                    state_next.carry    = aluBus.carryOut;
                end
                incdec_pkg::OP_DECREMENT_IN_PLACE_OP: begin
                    state_next.dataByte = aluBus.result;
                    state_next.zero     = aluBus.zeroOut;
                end
                incdec_pkg::OP_DECREMENT_TO_ACCUMULATOR_OP: begin
                    state_next.accumulator = aluBus.result;
                    state_next.zero        = aluBus.zeroOut;
                end
                incdec_pkg::OP_INCREMENT_IN_PLACE_OP: begin
                    state_next.dataByte = aluBus.result;
                    state_next.zero     = aluBus.zeroOut;
                end
                incdec_pkg::OP_POWER_DOWN_OP: begin
                    state_next.mode            = incdec_pkg::MODE_HALTED;
                    state_next.watchdogCounter = '0;
                    state_next.prescaler       = '0;
                    state_next.powerDownFlag   = 1'b1;
                    state_next.timeoutFlag     = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Wake only restarts the clock; contents are left as they were
        if (state_reg.mode == incdec_pkg::MODE_HALTED && wakeUp) begin
            state_next.mode = incdec_pkg::MODE_RUN;
        end
        // Read data is captured in setup so it stands through the access phase
        if (setupPhase) begin
            state_next.readData = 32'h0000_0000;
            case (paddr)
                incdec_pkg::ACCUM_OFS: state_next.readData[7:0] = state_reg.accumulator;
                incdec_pkg::DATA_OFS: state_next.readData[7:0] = state_reg.dataByte;
                incdec_pkg::FLAGS_OFS: begin
                    state_next.readData[incdec_pkg::CARRY_BIT] = state_reg.carry;
                    state_next.readData[incdec_pkg::AUX_BIT]   = state_reg.auxiliaryCarryFlag;
                    state_next.readData[incdec_pkg::ZERO_BIT]  = state_reg.zero;
                    state_next.readData[incdec_pkg::PWRDN_BIT] = state_reg.powerDownFlag;
                    state_next.readData[incdec_pkg::TMO_BIT]   = state_reg.timeoutFlag;
                end
                incdec_pkg::WATCHDOG_OFS: begin
                    state_next.readData[15:0] = {8'(state_reg.watchdogCounter),
                                                 8'(state_reg.prescaler)};
                end
                incdec_pkg::STATUS_OFS: begin
                    state_next.readData[incdec_pkg::HALTED_BIT] =
                        (state_reg.mode == incdec_pkg::MODE_HALTED);
                end
                default: begin
                end
            endcase
        end
    end

    // Single register bank for all state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg                    <= '0;
            state_reg.mode               <= incdec_pkg::MODE_RUN;
            state_reg.accumulator        <= incdec_pkg::ACCUM_RST;
            state_reg.dataByte           <= incdec_pkg::DATA_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs; unmapped addresses answer with an error and read zero
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~mapped(paddr);
    assign prdata        = state_reg.readData;
    assign sysClkOn      = (state_reg.mode == incdec_pkg::MODE_RUN);
    assign powerDownFlag = state_reg.powerDownFlag;
    assign timeoutFlag   = state_reg.timeoutFlag;

    // Helper views for the checks below
    logic [7:0] accNow;
    logic [7:0] dataNow;
    logic [3:0] accLow;
    logic [3:0] accHigh;
    logic       lowCond;
    logic       highCond;
    logic       anyWrite;
    logic       halted;
    assign accNow   = state_reg.accumulator;
    assign dataNow  = state_reg.dataByte;
    assign accLow   = state_reg.accumulator[3:0];
    assign accHigh  = state_reg.accumulator[7:4];
    assign lowCond  = (accLow > 4'h9) | state_reg.auxiliaryCarryFlag;
    assign highCond = (accHigh > 4'h9) | state_reg.carry;
    assign anyWrite = psel & penable & pwrite;
    assign halted   = (state_reg.mode == incdec_pkg::MODE_HALTED);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_BCD_LOW_ADD: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECIMAL_ADJUST_OP && lowCond
        |=> dataNow[3:0] == 4'($past(accLow) + 4'h6))
        else $error("low nibble not corrected by six");

    AST_BCD_LOW_KEEP: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECIMAL_ADJUST_OP && !lowCond
        |=> dataNow[3:0] == $past(accLow))
        else $error("low nibble changed without cause");

    AST_BCD_HIGH_ADD: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECIMAL_ADJUST_OP && highCond && !lowCond
        |=> dataNow[7:4] == 4'($past(accHigh) + 4'h6))
        else $error("high nibble not corrected by six");

    AST_BCD_ACCUM_KEPT: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECIMAL_ADJUST_OP
        |=> accNow == $past(accNow))
        else $error("decimal adjust altered the accumulator");

    AST_BCD_FLAGS: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECIMAL_ADJUST_OP && highCond
        |=> state_reg.carry && $stable(state_reg.zero) && $stable(state_reg.auxiliaryCarryFlag)
            && $stable(state_reg.powerDownFlag))
        else $error("decimal adjust flag update wrong");

    AST_DECR_MEM: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECREMENT_IN_PLACE_OP
        |=> dataNow == 8'($past(dataNow) - 8'h01) && $stable(accNow))
        else $error("in-place decrement wrong");

    AST_DECR_ACCUM: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_DECREMENT_TO_ACCUMULATOR_OP
        |=> accNow == 8'($past(dataNow) - 8'h01) && $stable(dataNow))
        else $error("decrement to accumulator wrong");

    AST_HALT_STOP: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_POWER_DOWN_OP
        |=> !sysClkOn)
        else $error("power-down did not stop execution");

    AST_HALT_IGNORE: assert property (
        halted && !wakeUp && cmdWrite
        |=> $stable(dataNow) && $stable(accNow) && halted)
        else $error("command executed while powered down");

    AST_HALT_KEEP: assert property (
        halted && !anyWrite
        |=> $stable(accNow) && $stable(dataNow) && $stable(state_reg.carry)
            && $stable(state_reg.watchdogCounter))
        else $error("contents lost while powered down");

    AST_HALT_WDT: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_POWER_DOWN_OP
        |=> state_reg.watchdogCounter == '0 && state_reg.prescaler == '0)
        else $error("watchdog not cleared on power-down");

    AST_HALT_FLAGS: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_POWER_DOWN_OP
        |=> powerDownFlag && !timeoutFlag && $stable(state_reg.zero))
        else $error("power-down flags wrong");

    AST_INC_MEM: assert property (
        cmdFire && cmdOp == incdec_pkg::OP_INCREMENT_IN_PLACE_OP
        |=> dataNow == 8'($past(dataNow) + 8'h01))
        else $error("in-place increment wrong");

    AST_ZERO_FLAG: assert property (
        cmdFire && (cmdOp == incdec_pkg::OP_DECREMENT_IN_PLACE_OP ||
                    cmdOp == incdec_pkg::OP_INCREMENT_IN_PLACE_OP)
        |=> state_reg.zero == (dataNow == 8'h00))
        else $error("zero flag does not match result");

    COV_BCD_BOTH: cover property (
        cmdFire && cmdOp == incdec_pkg::OP_DECIMAL_ADJUST_OP && lowCond && highCond);
    COV_DECR_ZERO: cover property (
        cmdFire && cmdOp == incdec_pkg::OP_DECREMENT_TO_ACCUMULATOR_OP && dataNow == 8'h01);
    COV_INC_WRAP: cover property (
        cmdFire && cmdOp == incdec_pkg::OP_INCREMENT_IN_PLACE_OP && dataNow == 8'hFF);
    COV_HALT_WAKE: cover property (
        cmdFire && cmdOp == incdec_pkg::OP_POWER_DOWN_OP ##[1:50] halted && wakeUp);

endmodule // decimal_adjust_incdec_halt_exec

// >>> verif/test_decimal_adjust_incdec_halt_exec.sv
// Purpose: Self-checking bench for the decimal-adjust / inc / dec / power-down unit
// Assumes: APB slave answers with pready; watchdog shortened through its width parameters
// Notes:   Every scenario is its own task; expectations are worked out here, not read back
`timescale 1ns/10ps
module test_decimal_adjust_incdec_halt_exec;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wakeUp;
    logic        sysClkOn;
    logic        powerDownFlag;
    logic        timeoutFlag;
    int          numErrors;
    int          checkCount;
    logic [31:0] rdData;
    logic        rdErr;

    // Small watchdog so a time-out shows up after sixteen clocks
    decimal_adjust_incdec_halt_exec #(.WATCHDOG_WIDTH(2), .PRESC_WIDTH(2)) uut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeUp(wakeUp), .sysClkOn(sysClkOn),
        .powerDownFlag(powerDownFlag), .timeoutFlag(timeoutFlag)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Single comparison point; unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic expect_reg(input logic [7:0] addr, input logic [31:0] exp,
                              input logic [31:0] mask);
        apb(1'b0, addr, 32'h0);
        check(rdData & mask, exp);
    endtask

    // Load operands and flags, then fire one command
    task automatic run_op(input logic [7:0] acc, input logic [7:0] dat,
                          input logic [2:0] flg, input incdec_pkg::op_t op);
        apb(1'b1, incdec_pkg::ACCUM_OFS, {24'h0, acc});
        apb(1'b1, incdec_pkg::DATA_OFS, {24'h0, dat});
        apb(1'b1, incdec_pkg::FLAGS_OFS, {29'h0, flg});
        apb(1'b1, incdec_pkg::CMD_OFS, {29'h0, op});
    endtask

    // Decimal adjust over a table of {accumulator, carry, aux carry}
    task automatic test_decimal_adjust();
        logic [9:0] cases [8];
        logic       lo;
        logic       hi;
        logic [8:0] s;
        cases = '{{8'h00, 2'h0}, {8'h0A, 2'h0}, {8'h12, 2'h1}, {8'hA2, 2'h0},
                  {8'h35, 2'h2}, {8'h99, 2'h0}, {8'hAB, 2'h0}, {8'h00, 2'h3}};
        foreach (cases[i]) begin
            lo = (cases[i][5:2] > 4'h9) || cases[i][0];
            hi = (cases[i][9:6] > 4'h9) || cases[i][1];
            s  = {1'b0, cases[i][9:2]} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
            // Zero flag preset to one so an unwanted update is seen
            // Flag register: bit 0 carry from case bit 1, bit 1 aux carry from case bit 0
            run_op(cases[i][9:2], 8'hC3, {1'b1, cases[i][0], cases[i][1]},
                   incdec_pkg::OP_DECIMAL_ADJUST_OP);
            expect_reg(incdec_pkg::DATA_OFS, {24'h0, s[7:0]}, 32'hFF);
            expect_reg(incdec_pkg::ACCUM_OFS, {24'h0, cases[i][9:2]}, 32'hFF);
            expect_reg(incdec_pkg::FLAGS_OFS,
                       {29'h0, 1'b1, cases[i][0], cases[i][1] | hi | s[8]}, 32'h7);
        end
        $display("decimal adjust test done");
    endtask

    // Decrement and increment at the wrap points, decrement to accumulator at 01H and 80H
    task automatic test_incdec();
        run_op(8'h77, 8'h01, 3'h0, incdec_pkg::OP_DECREMENT_IN_PLACE_OP);
        expect_reg(incdec_pkg::DATA_OFS, 32'h00, 32'hFF);
        expect_reg(incdec_pkg::FLAGS_OFS, 32'h4, 32'h7);
        run_op(8'h77, 8'h00, 3'h4, incdec_pkg::OP_DECREMENT_IN_PLACE_OP);
        expect_reg(incdec_pkg::DATA_OFS, 32'hFF, 32'hFF);
        expect_reg(incdec_pkg::FLAGS_OFS, 32'h0, 32'h7);
        run_op(8'h77, 8'h01, 3'h0, incdec_pkg::OP_DECREMENT_TO_ACCUMULATOR_OP);
        expect_reg(incdec_pkg::ACCUM_OFS, 32'h00, 32'hFF);
        expect_reg(incdec_pkg::DATA_OFS, 32'h01, 32'hFF);
        expect_reg(incdec_pkg::FLAGS_OFS, 32'h4, 32'h7);
        run_op(8'h00, 8'h80, 3'h4, incdec_pkg::OP_DECREMENT_TO_ACCUMULATOR_OP);
        expect_reg(incdec_pkg::ACCUM_OFS, 32'h7F, 32'hFF);
        expect_reg(incdec_pkg::FLAGS_OFS, 32'h0, 32'h7);
        run_op(8'h11, 8'hFF, 3'h0, incdec_pkg::OP_INCREMENT_IN_PLACE_OP);
        expect_reg(incdec_pkg::DATA_OFS, 32'h00, 32'hFF);
        expect_reg(incdec_pkg::ACCUM_OFS, 32'h11, 32'hFF);
        run_op(8'h11, 8'h41, 3'h0, incdec_pkg::OP_INCREMENT_IN_PLACE_OP);
        expect_reg(incdec_pkg::DATA_OFS, 32'h42, 32'hFF);
        // Unmapped place answers with an error and reads zero; command reads zero
        apb(1'b1, 8'h18, 32'h5A);
        check({31'h0, rdErr}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        check({rdData[30:0], rdErr}, 32'h1);
        expect_reg(incdec_pkg::CMD_OFS, 32'h0, 32'hFFFFFFFF);
        $display("increment and decrement test done");
    endtask

    // Power-down: flags, watchdog, retention, ignored commands, wake
    task automatic test_power_down();
        repeat (40) @(posedge clk);
        check({31'h0, timeoutFlag}, 32'h1);
        run_op(8'h3C, 8'h5A, 3'h0, incdec_pkg::OP_POWER_DOWN_OP);
        @(posedge clk);
        check({30'h0, sysClkOn, powerDownFlag}, 32'h1);
        check({31'h0, timeoutFlag}, 32'h0);
        expect_reg(incdec_pkg::WATCHDOG_OFS, 32'h0, 32'hFFFF);
        expect_reg(incdec_pkg::STATUS_OFS, 32'h1, 32'h1);
        expect_reg(incdec_pkg::FLAGS_OFS, 32'h08, 32'h1F);
        apb(1'b1, incdec_pkg::CMD_OFS, {29'h0, incdec_pkg::OP_INCREMENT_IN_PLACE_OP});
        repeat (20) @(posedge clk);
        expect_reg(incdec_pkg::DATA_OFS, 32'h5A, 32'hFF);
        expect_reg(incdec_pkg::ACCUM_OFS, 32'h3C, 32'hFF);
        expect_reg(incdec_pkg::WATCHDOG_OFS, 32'h0, 32'hFFFF);
        wakeUp <= 1'b1;
        @(posedge clk);
        wakeUp <= 1'b0;
        @(posedge clk);
        check({31'h0, sysClkOn}, 32'h1);
        // Power-down flag is read-only: a clearing write leaves it set
        apb(1'b1, incdec_pkg::FLAGS_OFS, 32'h0);
        expect_reg(incdec_pkg::FLAGS_OFS, 32'h08, 32'h0F);
        apb(1'b1, incdec_pkg::CMD_OFS, {29'h0, incdec_pkg::OP_INCREMENT_IN_PLACE_OP});
        expect_reg(incdec_pkg::DATA_OFS, 32'h5B, 32'hFF);
        $display("power-down test done");
    endtask

    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence; reset held for ten clocks
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wakeUp = 1'b0;
        numErrors = 0;
        checkCount = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_decimal_adjust();
        test_incdec();
        test_power_down();
        endOfTest();
    end

    // Watchdog: whole run needs well under two thousand clocks
    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        endOfTest();
    end
endmodule // test_decimal_adjust_incdec_halt_exec
